// *** common/amm_pkg.sv ***
// Constants, layouts and types of the modem management command block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package amm_pkg;
    // Request framing and command codes
    localparam logic [7:0] SUB_CODE = 8'h01;
    localparam logic [7:0] CMD_CFG_MODEM = 8'h0E;
    localparam logic [7:0] CMD_OWNER = 8'h0F;
    localparam logic [7:0] CMD_CLR_POOL = 8'h10;
    localparam logic [7:0] CMD_NV_CONN = 8'h11;
    localparam logic [7:0] CMD_JOIN_CONN = 8'h12;
    localparam logic [7:0] CMD_CALLBACK = 8'h13;
    localparam logic [7:0] CMD_CFG_REPORT = 8'h14;
    // Response codes
    localparam logic [7:0] RESP_GRANT = 8'h3D;
    localparam logic [7:0] RESP_DENY = 8'h1D;
    localparam logic [7:0] RESP_OK = 8'h01;
    localparam logic [7:0] RESP_FAIL = 8'h00;
    // Setting values
    localparam logic [7:0] CONN_OFF = 8'hFF;
    localparam logic [7:0] CALLBACK_OFF = 8'h00;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_REQ = 8'h04;
    localparam logic [7:0] OFF_RESP = 8'h08;
    localparam logic [7:0] OFF_REPORT = 8'h0C;
    localparam logic [7:0] OFF_SETTINGS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // Field positions
    localparam int CTRL_NSM = 0;
    localparam int REQ_CMD = 8;
    localparam int REQ_ARG = 16;
    localparam int REQ_NODE = 24;
    localparam int RESP_OK_BIT = 8;
    localparam int RESP_OWNED = 9;
    localparam int RESP_REPORTED = 10;
    localparam int RESP_OWNER = 16;
    // Event bits
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DIAL = 1;
    localparam int IRQ_CFG = 2;
    localparam int IRQ_DROP = 3;
    // Configuration record report; arbitrary neutral values
    localparam logic [15:0] REC_ADDR = 16'h0100;
    localparam logic [7:0] REC_REV = 8'h01;
    localparam logic [7:0] REC_LEN = 8'h20;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] nv_conn;
        logic [7:0] join_conn;
        logic [7:0] callback;
    } amm_settings_s;

    typedef struct packed {
        logic link_up;
        logic nv_update;
        logic join_msg;
        logic dial_in;
        logic [3:0] dial_in_dir;
    } amm_pins_s;
endpackage

// *** src/amm_mgmt.sv ***
// Management request interpreter for a modem-attached serial adapter.
// Assumes a classic Wishbone master and asynchronous modem status pins.
//
// The Wishbone register port and the register addresses are this design's own decisions.

// Behaviour
// - Configure-modem request sends config string when link is down.
// - Configure-modem while connected sends nothing and answers failure.
// - Ownership request code 15; true asks, false gives back.
// - Ownership answers 0x3D when granted, 0x1D when denied.
// - Ownership is lost on reset; nobody owns afterwards.
// - Clear-pool request code 16 empties all strings to null.
// - Code 17 in services mode writes variable-update dial byte.
// - In services mode, enabled variable-update setting starts dial-out on each update.
// - Code 18 in services mode writes join dial byte.
// - In services mode, enabled join setting starts dial-out on each join message.
// - Code 19 in services mode writes callback byte; nonzero enables.
// - Callback: dial-in is hung up, then dial-out to requested entry.
// - Report request in services mode gives record address, revision and length.
// - Requests start with sub-code 1, then command, then fields.
// - Config string also sent after reset and on link loss.
module amm_mgmt (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire amm_pkg::amm_pins_s pins_in,
    output logic send_cfg_out,
    output logic clear_pool_out,
    output logic dial_out_out,
    output logic [3:0] dial_dir_out,
    output logic hangup_out,
    output logic irq_out
);
    import amm_pkg::*;

    function automatic logic conn_on(input logic [7:0] v);
        conn_on = (v != CONN_OFF);
    endfunction
    amm_pins_s s1_r, s2_r, s3_r;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic nsm_r, nsm_nxt;
    amm_settings_s set_r, set_nxt;
    logic owned_r, owned_nxt;
    logic [7:0] owner_r, owner_nxt;
    logic [7:0] resp_r, resp_nxt;
    logic ok_r, ok_nxt, rep_r, rep_nxt;
    logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic boot_r, boot_nxt, cbp_r, cbp_nxt;
    logic cfg_r, cfg_nxt, clr_r, clr_nxt, dial_r, dial_nxt, hup_r, hup_nxt;
    logic [3:0] dir_r, dir_nxt;
    logic req, exec, wr, rd;
    logic [7:0] cmd, arg, node;
    logic sub_ok, nv_ev, join_ev, din_ev, drop_ev;
    logic [31:0] rdata;
    logic [IRQ_W-1:0] ev;
    assign req = wb_cyc_in & wb_stb_in;
    assign wr = req & ack_r & wb_we_in;
    assign rd = req & ack_r & ~wb_we_in;
    assign exec = wr & (wb_adr_in == OFF_REQ);
    assign cmd = wb_dat_in[REQ_CMD +: 8];
    assign arg = wb_dat_in[REQ_ARG +: 8];
    assign node = wb_dat_in[REQ_NODE +: 8];
    assign sub_ok = (wb_dat_in[7:0] == SUB_CODE);
    assign nv_ev = s2_r.nv_update & ~s3_r.nv_update;
    assign join_ev = s2_r.join_msg & ~s3_r.join_msg;
    assign din_ev = s2_r.dial_in & ~s3_r.dial_in;
    assign drop_ev = ~s2_r.link_up & s3_r.link_up;
    assign wb_dat_out = dat_r;
    assign wb_ack_out = ack_r;
    assign send_cfg_out = cfg_r;
    assign clear_pool_out = clr_r;
    assign dial_out_out = dial_r;
    assign dial_dir_out = dir_r;
    assign hangup_out = hup_r;
    assign irq_out = |(ist_r & imask_r);
    always_comb begin
        rdata = ZERO32;
        unique case (wb_adr_in)
            OFF_CTRL: rdata[CTRL_NSM] = nsm_r;
            OFF_RESP: begin
                rdata[7:0] = resp_r;
                rdata[RESP_OK_BIT] = ok_r;
                rdata[RESP_OWNED] = owned_r;
                rdata[RESP_REPORTED] = rep_r;
                rdata[RESP_OWNER +: 8] = owner_r;
            end
            OFF_REPORT: rdata = {REC_LEN, REC_REV, REC_ADDR};
            OFF_SETTINGS: rdata[23:0] = set_r;
            OFF_IRQ_STAT: rdata[IRQ_W-1:0] = ist_r;
            OFF_IRQ_MASK: rdata[IRQ_W-1:0] = imask_r;
            default: rdata = ZERO32;
        endcase
    end

    always_comb begin
        ack_nxt = req & ~ack_r;
        dat_nxt = (req & ~ack_r) ? rdata : dat_r;
        nsm_nxt = nsm_r;
        set_nxt = set_r;
        owned_nxt = owned_r;
        owner_nxt = owner_r;
        resp_nxt = resp_r;
        ok_nxt = ok_r;
        rep_nxt = rep_r;
        imask_nxt = imask_r;
        boot_nxt = 1'b0;
        cbp_nxt = 1'b0;
        cfg_nxt = 1'b0;
        clr_nxt = 1'b0;
        dial_nxt = 1'b0;
        hup_nxt = 1'b0;
        dir_nxt = dir_r;
        ev = '0;
        if (wr && wb_adr_in == OFF_CTRL && wb_sel_in[0])
            nsm_nxt = wb_dat_in[CTRL_NSM];
        if (wr && wb_adr_in == OFF_IRQ_MASK && wb_sel_in[0])
            imask_nxt = wb_dat_in[IRQ_W-1:0];
        if (exec) begin
            ev[IRQ_DONE] = 1'b1;
            resp_nxt = RESP_FAIL;
            ok_nxt = 1'b0;
            if (sub_ok) begin
                unique case (cmd)
                    CMD_CFG_MODEM:
                        if (!s2_r.link_up) begin
                            cfg_nxt = 1'b1;
                            resp_nxt = RESP_OK;
                            ok_nxt = 1'b1;
                        end
                    CMD_OWNER: begin
                        if (arg != 8'h00 && (!owned_r || owner_r == node)) begin
                            owned_nxt = 1'b1;
                            owner_nxt = node;
                            resp_nxt = RESP_GRANT;
                            ok_nxt = 1'b1;
                        end else if (arg == 8'h00 && owned_r
                                     && owner_r == node) begin
                            owned_nxt = 1'b0;
                            resp_nxt = RESP_GRANT;
                            ok_nxt = 1'b1;
                        end else
                            resp_nxt = RESP_DENY;
                    end
                    CMD_CLR_POOL: begin
                        clr_nxt = 1'b1;
                        resp_nxt = RESP_OK;
                        ok_nxt = 1'b1;
                    end
                    CMD_NV_CONN, CMD_JOIN_CONN, CMD_CALLBACK,
                    CMD_CFG_REPORT: begin
                        if (nsm_r) begin
                            resp_nxt = RESP_OK;
                            ok_nxt = 1'b1;
                            if (cmd == CMD_NV_CONN)
                                set_nxt.nv_conn = arg;
                            if (cmd == CMD_JOIN_CONN)
                                set_nxt.join_conn = arg;
                            if (cmd == CMD_CALLBACK)
                                set_nxt.callback = arg;
                            if (cmd == CMD_CFG_REPORT)
                                rep_nxt = 1'b1;
                        end
                    end
                    default: resp_nxt = RESP_FAIL;
                endcase
            end
        end
        if (boot_r || drop_ev)
            cfg_nxt = 1'b1;
        if (nsm_r && ((nv_ev && conn_on(set_r.nv_conn))
                      || (join_ev && conn_on(set_r.join_conn)))) begin
            dial_nxt = 1'b1;
            dir_nxt = nv_ev ? set_r.nv_conn[3:0] : set_r.join_conn[3:0];
        end
        if (nsm_r && din_ev && set_r.callback != CALLBACK_OFF) begin
            hup_nxt = 1'b1;
            cbp_nxt = 1'b1;
            dir_nxt = s2_r.dial_in_dir;
        end
        if (cbp_r) begin
            dial_nxt = 1'b1;
            dir_nxt = dir_r;
        end
        ev[IRQ_DIAL] = dial_nxt;
        ev[IRQ_CFG] = cfg_nxt;
        ev[IRQ_DROP] = drop_ev;
        // Read clears only bits already returned; set wins
        ist_nxt = (rd && wb_adr_in == OFF_IRQ_STAT) ?
                  ((ist_r & ~dat_r[IRQ_W-1:0]) | ev) : (ist_r | ev);
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dat_r <= ZERO32;
            ack_r <= 1'b0;
            nsm_r <= 1'b0;
            set_r <= {CONN_OFF, CONN_OFF, CALLBACK_OFF};
            owned_r <= 1'b0;
            owner_r <= 8'h00;
            resp_r <= RESP_FAIL;
            ok_r <= 1'b0;
            rep_r <= 1'b0;
            ist_r <= '0;
            imask_r <= '0;
            boot_r <= 1'b1;
            cbp_r <= 1'b0;
            cfg_r <= 1'b0;
            clr_r <= 1'b0;
            dial_r <= 1'b0;
            hup_r <= 1'b0;
            dir_r <= 4'h0;
        end else begin
            s1_r <= pins_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            nsm_r <= nsm_nxt;
            set_r <= set_nxt;
            owned_r <= owned_nxt;
            owner_r <= owner_nxt;
            resp_r <= resp_nxt;
            ok_r <= ok_nxt;
            rep_r <= rep_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            boot_r <= boot_nxt;
            cbp_r <= cbp_nxt;
            cfg_r <= cfg_nxt;
            clr_r <= clr_nxt;
            dial_r <= dial_nxt;
            hup_r <= hup_nxt;
            dir_r <= dir_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_cfg_req;
        exec && sub_ok && cmd == CMD_CFG_MODEM;
    endsequence
    sequence s_callback;
        nsm_r && din_ev && set_r.callback != CALLBACK_OFF;
    endsequence
    property p_cfg_sent;
        s_cfg_req and !s2_r.link_up |=> send_cfg_out && ok_r;
    endproperty
    a_cfg_sent: assert property (p_cfg_sent)
        else $error("config string not sent");
    property p_cfg_busy;
        s_cfg_req and s2_r.link_up and !drop_ev
            |=> !send_cfg_out && resp_r == RESP_FAIL;
    endproperty
    a_cfg_busy: assert property (p_cfg_busy)
        else $error("configure while connected not refused");
    property p_grant;
        exec && sub_ok && cmd == CMD_OWNER && arg != 8'h00 && !owned_r
            |=> resp_r == RESP_GRANT && owned_r && owner_r == $past(node);
    endproperty
    a_grant: assert property (p_grant)
        else $error("ownership not granted");
    property p_deny;
        exec && sub_ok && cmd == CMD_OWNER && owned_r && owner_r != node
            |=> resp_r == RESP_DENY && $stable(owner_r);
    endproperty
    a_deny: assert property (p_deny)
        else $error("foreign ownership request not denied");
    property p_boot;
        boot_r ##1 !boot_r |-> !owned_r && send_cfg_out;
    endproperty
    a_boot: assert property (p_boot)
        else $error("bad state after reset");
    property p_drop;
        drop_ev |=> send_cfg_out;
    endproperty
    a_drop: assert property (p_drop)
        else $error("config string not sent on link loss");
    property p_clear;
        exec && sub_ok && cmd == CMD_CLR_POOL |=> clear_pool_out;
    endproperty
    a_clear: assert property (p_clear)
        else $error("pool not cleared");
    property p_nv_write;
        exec && sub_ok && nsm_r && cmd == CMD_NV_CONN
            |=> set_r.nv_conn == $past(arg);
    endproperty
    a_nv_write: assert property (p_nv_write)
        else $error("update dial byte not written");
    property p_nv_dial;
        nsm_r && nv_ev && conn_on(set_r.nv_conn) |=> dial_out_out;
    endproperty
    a_nv_dial: assert property (p_nv_dial)
        else $error("no dial-out on variable update");
    property p_join_dial;
        nsm_r && join_ev && conn_on(set_r.join_conn) |=> dial_out_out;
    endproperty
    a_join_dial: assert property (p_join_dial)
        else $error("no dial-out on join message");
    property p_callback;
        s_callback |=> hangup_out ##1 (dial_out_out
            && dial_dir_out == $past(s2_r.dial_in_dir, 2));
    endproperty
    a_callback: assert property (p_callback)
        else $error("callback sequence wrong");
    property p_wrong_mode;
        exec && !nsm_r && (cmd == CMD_NV_CONN || cmd == CMD_JOIN_CONN)
            |=> $stable(set_r) && resp_r == RESP_FAIL;
    endproperty
    a_wrong_mode: assert property (p_wrong_mode)
        else $error("wrong-mode command accepted");
    property p_sub;
        exec && !sub_ok |=> resp_r == RESP_FAIL && !ok_r;
    endproperty
    a_sub: assert property (p_sub)
        else $error("bad sub-code accepted");
endmodule

// *** testbench/amm_mgmt_bench.sv ***
// Self-checking bench for the management request block.
// Assumes the modem model on the pins and a Wishbone master here.
module amm_mgmt_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import amm_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, scfg, clr, dial, hup, irq;
    logic [3:0] dir;
    logic link = 1'b0, nv = 1'b0, jn = 1'b0, din = 1'b0;
    logic [3:0] din_dir = 4'h0, last_dir;
    logic [7:0] cfg_cnt, clr_cnt, dial_cnt, hup_cnt;
    amm_pins_s pins;
    int mismatches = 0;
    int tests_run = 0;
    // Node, field, expected answer
    logic [23:0] own_tab [5] = '{24'h01013D, 24'h02011D, 24'h02001D,
                                 24'h01003D, 24'h02013D};

    always #2 clk = ~clk;

    amm_mgmt uut (.ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .pins_in(pins), .send_cfg_out(scfg), .clear_pool_out(clr),
        .dial_out_out(dial), .dial_dir_out(dir), .hangup_out(hup),
        .irq_out(irq));
    amm_modem_model modem (.clk_in(clk), .nrst_in(nrst), .link_in(link),
        .nv_in(nv), .join_in(jn), .din_in(din), .din_dir_in(din_dir),
        .send_cfg_in(scfg), .clear_pool_in(clr), .dial_in(dial),
        .dial_dir_in(dir), .hangup_in(hup), .pins_out(pins),
        .cfg_cnt_out(cfg_cnt), .clr_cnt_out(clr_cnt),
        .dial_cnt_out(dial_cnt), .hup_cnt_out(hup_cnt),
        .last_dir_out(last_dir));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic req(input logic [7:0] sb, input logic [7:0] cmd,
                       input logic [7:0] arg, input logic [7:0] node,
                       input logic [7:0] exp);
        xfer(1'b1, OFF_REQ, {node, arg, cmd, sb});
        xfer(1'b0, OFF_RESP, 32'h0);
        chk({24'h0, q[7:0]}, {24'h0, exp});
    endtask

    task automatic ev(input int k, input logic [3:0] d);
        @(posedge clk);
        din_dir <= d;
        nv <= (k == 0);
        jn <= (k == 1);
        din <= (k == 2);
        @(posedge clk);
        {nv, jn, din} <= 3'h0;
        idle(12);
    endtask

    task finish_test;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        idle(20000);
        mismatches++;
        finish_test;
    end

    initial begin
        idle(5);
        nrst <= 1'b1;
        idle(10);
        xfer(1'b0, OFF_SETTINGS, 32'h0);
        chk(q, 32'h00FFFF00);
        chk({24'h0, cfg_cnt}, 32'h1);
        $display("test reset done");
        req(SUB_CODE, CMD_CFG_MODEM, 8'h00, 8'h01, RESP_OK);
        idle(3);
        chk({24'h0, cfg_cnt}, 32'h2);
        link <= 1'b1;
        idle(10);
        req(SUB_CODE, CMD_CFG_MODEM, 8'h00, 8'h01, RESP_FAIL);
        idle(3);
        chk({24'h0, cfg_cnt}, 32'h2);
        link <= 1'b0;
        idle(10);
        chk({24'h0, cfg_cnt}, 32'h3);
        $display("test configure done");
        for (int i = 0; i < 5; i++)
            req(SUB_CODE, CMD_OWNER, own_tab[i][15:8], own_tab[i][23:16],
                own_tab[i][7:0]);
        chk({23'h0, q[RESP_OWNED], q[23:16]}, 32'h102);
        req(SUB_CODE, CMD_CLR_POOL, 8'h00, 8'h01, RESP_OK);
        idle(3);
        chk({24'h0, clr_cnt}, 32'h1);
        $display("test ownership done");
        req(SUB_CODE, CMD_NV_CONN, 8'h23, 8'h01, RESP_FAIL);
        req(SUB_CODE, CMD_CFG_REPORT, 8'h00, 8'h01, RESP_FAIL);
        req(8'h02, CMD_CFG_MODEM, 8'h00, 8'h01, RESP_FAIL);
        req(SUB_CODE, 8'h22, 8'h00, 8'h01, RESP_FAIL);
        idle(3);
        chk({24'h0, cfg_cnt}, 32'h3);
        xfer(1'b0, OFF_SETTINGS, 32'h0);
        chk(q, 32'h00FFFF00);
        xfer(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        $display("test refusals done");
        xfer(1'b1, OFF_CTRL, 32'h1);
        req(SUB_CODE, CMD_NV_CONN, 8'h23, 8'h01, RESP_OK);
        req(SUB_CODE, CMD_JOIN_CONN, 8'h45, 8'h01, RESP_OK);
        req(SUB_CODE, CMD_CALLBACK, 8'h01, 8'h01, RESP_OK);
        xfer(1'b0, OFF_SETTINGS, 32'h0);
        chk(q, 32'h00234501);
        req(SUB_CODE, CMD_CFG_REPORT, 8'h00, 8'h01, RESP_OK);
        chk({31'h0, q[RESP_REPORTED]}, 32'h1);
        xfer(1'b0, OFF_REPORT, 32'h0);
        chk(q, {REC_LEN, REC_REV, REC_ADDR});
        $display("test services mode done");
        ev(0, 4'h0);
        chk({20'h0, dial_cnt, last_dir}, 32'h013);
        ev(1, 4'h0);
        chk({20'h0, dial_cnt, last_dir}, 32'h025);
        ev(2, 4'h7);
        chk({16'h0, hup_cnt, dial_cnt}, 32'h0103);
        chk({28'h0, last_dir}, 32'h7);
        $display("test dial-out done");
        xfer(1'b1, OFF_IRQ_MASK, 32'h2);
        idle(1);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk(q & 32'h2, 32'h2);
        idle(1);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        @(posedge clk);
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        idle(10);
        xfer(1'b0, OFF_RESP, 32'h0);
        chk({31'h0, q[RESP_OWNED]}, 32'h0);
        xfer(1'b0, OFF_SETTINGS, 32'h0);
        chk(q, 32'h00FFFF00);
        req(SUB_CODE, CMD_OWNER, 8'h01, 8'h03, RESP_GRANT);
        chk({24'h0, cfg_cnt}, 32'h1);
        $display("test second reset done");
        finish_test;
    end
endmodule

// *** testbench/amm_modem_model.sv ***
// Modem and line model on the pin side of the management block.
// Assumes one-cycle bench strobes, synchronous to the block's clock.
module amm_modem_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic link_in,
    input wire logic nv_in,
    input wire logic join_in,
    input wire logic din_in,
    input wire logic [3:0] din_dir_in,
    input wire logic send_cfg_in,
    input wire logic clear_pool_in,
    input wire logic dial_in,
    input wire logic [3:0] dial_dir_in,
    input wire logic hangup_in,
    output amm_pkg::amm_pins_s pins_out,
    output logic [7:0] cfg_cnt_out,
    output logic [7:0] clr_cnt_out,
    output logic [7:0] dial_cnt_out,
    output logic [7:0] hup_cnt_out,
    output logic [3:0] last_dir_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import amm_pkg::*;
    logic [3:0] nv_r, join_r, din_r;
    logic hung_r;

    // Events stretched so the pin synchronisers see them
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nv_r <= 4'h0;
            join_r <= 4'h0;
            din_r <= 4'h0;
            hung_r <= 1'b0;
            cfg_cnt_out <= 8'h00;
            clr_cnt_out <= 8'h00;
            dial_cnt_out <= 8'h00;
            hup_cnt_out <= 8'h00;
            last_dir_out <= 4'h0;
        end else begin
            nv_r <= nv_in ? 4'hF : nv_r >> 1;
            join_r <= join_in ? 4'hF : join_r >> 1;
            din_r <= din_in ? 4'hF : din_r >> 1;
            hung_r <= hangup_in | (hung_r & link_in);
            cfg_cnt_out <= cfg_cnt_out + {7'h00, send_cfg_in};
            clr_cnt_out <= clr_cnt_out + {7'h00, clear_pool_in};
            dial_cnt_out <= dial_cnt_out + {7'h00, dial_in};
            hup_cnt_out <= hup_cnt_out + {7'h00, hangup_in};
            if (dial_in) begin
                last_dir_out <= dial_dir_in;
            end
        end
    end

    // Hangup drops the carrier; directory lines junk outside a dial-in
    assign pins_out = {link_in & ~hung_r, nv_r[0], join_r[0], din_r[0],
                       (din_r != 4'h0) ? din_dir_in : ~din_dir_in};
endmodule
